/* rss_consts.svh */
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
// register byte offsets
`define RSS_OFF_CTRL 12'h000
`define RSS_OFF_STATUS 12'h004
`define RSS_OFF_ACCUM 12'h008
`define RSS_OFF_LIM_LO 12'h00C
`define RSS_OFF_LIM_HI 12'h010
`define RSS_OFF_RCOUNT 12'h014
`define RSS_OFF_SEG_BASE 12'h040
`define RSS_OFF_SEG_END 12'h080
// segment control word field positions
`define RSS_LEN_MSB 16
`define RSS_FAST_BIT 17
`define RSS_HALF_BIT 18
`define RSS_MARK_LSB 19
`define RSS_CLR_BIT 21
`define RSS_ADV_LSB 22
`define RSS_SUCC_LSB 24
// reset values, segment count and maximum segment length
`define RSS_LIM_LO_RST 32'h80000000
`define RSS_LIM_HI_RST 32'h7FFFFFFF
`define RSS_SEG_NUM 8
`define RSS_LEN_MAX 17'h10000
`endif

/* rss_pkg.sv */
package rss_pkg;
    typedef struct packed {
        logic [29:0] step;
        logic [16:0] len;
        logic fast;
        logic half;
        logic [1:0] marker;
        logic clr;
        logic [1:0] adv;
        logic [2:0] succ;
    } rss_seg_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rss_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rss_apb_rsp_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } rss_state_type;
endpackage

/* rss_ramp_segment_sequencer.sv */
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_ramp_segment_sequencer #(
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rss_pkg::rss_apb_req_type apbReq,
    output rss_pkg::rss_apb_rsp_type apbRsp,
    input wire logic [2:0] triggerPins,
    output logic [31:0] rampValue,
    output logic segmentFastSettle,
    output logic markerOutputLow,
    output logic markerOutputHigh
);
    import rss_pkg::*;

    if (CNT_W < 1 || CNT_W > 32) begin : g_cntWCheck
        $error("CNT_W must lie in 1..32");
    end

    rss_seg_type cfg_q [`RSS_SEG_NUM];
    rss_seg_type cfg_d [`RSS_SEG_NUM];
    logic runEn_q, runEn_d;
    logic [1:0] stepSrc_q, stepSrc_d;
    logic [31:0] limLo_q, limLo_d, limHi_q, limHi_d;
    rss_apb_rsp_type rsp_q, rsp_d;
    rss_state_type state_q, state_d;
    logic [2:0] segIdx_q, segIdx_d;
    logic enter_q, enter_d, phase_q, phase_d;
    logic [16:0] tickCnt_q, tickCnt_d;
    logic [31:0] acc_q, acc_d;
    logic [CNT_W-1:0] rCount_q, rCount_d;
    logic fast_q, fast_d;
    logic [1:0] mark_q, mark_d;
    logic [2:0] trigS1_q, trigS2_q, trigS3_q;
    logic [2:0] trigEdge;
    rss_seg_type cur;
    logic tickNow, endNow, wrEn;
    logic signed [32:0] sum;

    // pins cross in through two flops; edge taken after the second
    assign trigEdge = trigS2_q & ~trigS3_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trigS1_q <= 3'h0;
            trigS2_q <= 3'h0;
            trigS3_q <= 3'h0;
        end else begin
            trigS1_q <= triggerPins;
            trigS2_q <= trigS1_q;
            trigS3_q <= trigS2_q;
        end
    end

    // register file over apb; answer comes one cycle into the access phase
    assign wrEn = apbReq.psel & apbReq.penable & rsp_q.pready & apbReq.pwrite;
    always_comb begin
        logic [2:0] wi;
        logic segHit;
        wi = apbReq.paddr[5:3];
        segHit = apbReq.paddr >= `RSS_OFF_SEG_BASE && apbReq.paddr < `RSS_OFF_SEG_END;
        cfg_d = cfg_q;
        runEn_d = runEn_q;
        stepSrc_d = stepSrc_q;
        limLo_d = limLo_q;
        limHi_d = limHi_q;
        rsp_d = '0;
        rsp_d.pready = apbReq.psel & apbReq.penable & ~rsp_q.pready;
        if (segHit) begin
            if (!apbReq.paddr[2]) begin
                rsp_d.prdata = {2'h0, cfg_q[wi].step};
            end else begin
                rsp_d.prdata = {5'h00, cfg_q[wi].succ, cfg_q[wi].adv, cfg_q[wi].clr,
                                cfg_q[wi].marker, cfg_q[wi].half, cfg_q[wi].fast,
                                cfg_q[wi].len};
            end
        end else begin
            unique case (apbReq.paddr)
                `RSS_OFF_CTRL: rsp_d.prdata = {29'h0, stepSrc_q, runEn_q};
                `RSS_OFF_STATUS: rsp_d.prdata = {28'h0, segIdx_q, state_q == ST_RUN};
                `RSS_OFF_ACCUM: rsp_d.prdata = acc_q;
                `RSS_OFF_LIM_LO: rsp_d.prdata = limLo_q;
                `RSS_OFF_LIM_HI: rsp_d.prdata = limHi_q;
                `RSS_OFF_RCOUNT: rsp_d.prdata = 32'(rCount_q);
                default: rsp_d.pslverr = rsp_d.pready;
            endcase
        end
        if (wrEn && segHit) begin
            if (!apbReq.paddr[2]) begin
                cfg_d[wi].step = apbReq.pwdata[29:0];
            end else begin
                cfg_d[wi].len = apbReq.pwdata[`RSS_LEN_MSB:0];
                cfg_d[wi].fast = apbReq.pwdata[`RSS_FAST_BIT];
                cfg_d[wi].half = apbReq.pwdata[`RSS_HALF_BIT];
                cfg_d[wi].marker = apbReq.pwdata[`RSS_MARK_LSB +: 2];
                cfg_d[wi].clr = apbReq.pwdata[`RSS_CLR_BIT];
                cfg_d[wi].adv = apbReq.pwdata[`RSS_ADV_LSB +: 2];
                cfg_d[wi].succ = apbReq.pwdata[`RSS_SUCC_LSB +: 3];
            end
        end else if (wrEn) begin
            unique case (apbReq.paddr)
                `RSS_OFF_CTRL: begin
                    runEn_d = apbReq.pwdata[0];
                    stepSrc_d = apbReq.pwdata[2:1];
                end
                `RSS_OFF_LIM_LO: limLo_d = apbReq.pwdata;
                `RSS_OFF_LIM_HI: limHi_d = apbReq.pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `RSS_SEG_NUM; i++) begin
                cfg_q[i] <= '0;
            end
            runEn_q <= 1'b0;
            stepSrc_q <= 2'h0;
            limLo_q <= `RSS_LIM_LO_RST;
            limHi_q <= `RSS_LIM_HI_RST;
            rsp_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            runEn_q <= runEn_d;
            stepSrc_q <= stepSrc_d;
            limLo_q <= limLo_d;
            limHi_q <= limHi_d;
            rsp_q <= rsp_d;
        end
    end

    // sequencer
    assign cur = cfg_q[segIdx_q];
    assign tickNow = state_q == ST_RUN && !enter_q && tickCnt_q < cur.len &&
                     (!cur.half || phase_q);
    assign endNow = state_q == ST_RUN && !enter_q &&
                    (cur.adv == 2'h0 ? tickCnt_q >= cur.len : trigEdge[cur.adv - 2'h1]);
    assign sum = $signed({acc_q[31], acc_q}) + $signed({{3{cur.step[29]}}, cur.step});

    always_comb begin
        state_d = state_q;
        segIdx_d = segIdx_q;
        enter_d = 1'b0;
        phase_d = 1'b0;
        tickCnt_d = tickCnt_q;
        acc_d = acc_q;
        rCount_d = rCount_q;
        if (state_q == ST_IDLE) begin
            if (runEn_q) begin
                state_d = ST_RUN;
                segIdx_d = 3'h0;
                enter_d = 1'b1;
            end
        end else if (!runEn_q) begin
            state_d = ST_IDLE;
        end else if (enter_q) begin
            tickCnt_d = 17'h0;
            if (cur.clr) begin
                acc_d = 32'h0;
            end
        end else begin
            phase_d = cur.half & ~phase_q;
            if (tickNow) begin
                tickCnt_d = tickCnt_q + 17'h1;
                if (sum > $signed({limHi_q[31], limHi_q})) begin
                    acc_d = limHi_q;
                end else if (sum < $signed({limLo_q[31], limLo_q})) begin
                    acc_d = limLo_q;
                end else begin
                    acc_d = sum[31:0];
                end
            end
            if (endNow) begin
                segIdx_d = cur.succ;
                enter_d = 1'b1;
            end
        end
        if (stepSrc_q == 2'h0 ? endNow : trigEdge[stepSrc_q - 2'h1]) begin
            rCount_d = rCount_q + CNT_W'(1);
        end
        fast_d = state_d == ST_RUN && cfg_q[segIdx_d].fast;
        mark_d = state_d == ST_RUN ? cfg_q[segIdx_d].marker : 2'h0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            segIdx_q <= 3'h0;
            enter_q <= 1'b0;
            phase_q <= 1'b0;
            tickCnt_q <= 17'h0;
            acc_q <= 32'h0;
            rCount_q <= '0;
            fast_q <= 1'b0;
            mark_q <= 2'h0;
        end else begin
            state_q <= state_d;
            segIdx_q <= segIdx_d;
            enter_q <= enter_d;
            phase_q <= phase_d;
            tickCnt_q <= tickCnt_d;
            acc_q <= acc_d;
            rCount_q <= rCount_d;
            fast_q <= fast_d;
            mark_q <= mark_d;
        end
    end

    assign apbRsp = rsp_q;
    assign rampValue = acc_q;
    assign segmentFastSettle = fast_q;
    assign markerOutputLow = mark_q[0];
    assign markerOutputHigh = mark_q[1];

    sequence s_segEnd;
        endNow && runEn_q;
    endsequence
    sequence s_nextEnter(logic [2:0] idx);
        enter_q && segIdx_q == idx;
    endsequence

    property p_clear;
        @(posedge clk) disable iff (!nrst) enter_q && cur.clr && runEn_q |=> acc_q == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not cleared");
    property p_marker;
        @(posedge clk) disable iff (!nrst)
            state_q == ST_RUN |-> mark_q == cur.marker || $changed(cfg_q[segIdx_q]);
    endproperty
    a_marker: assert property (p_marker) else $error("marker mismatch");
    property p_fast;
        @(posedge clk) disable iff (!nrst)
            state_q == ST_IDLE |-> !segmentFastSettle && mark_q == 2'h0;
    endproperty
    a_fast: assert property (p_fast) else $error("outputs active while idle");
    property p_half;
        @(posedge clk) disable iff (!nrst) tickNow && cur.half && !endNow |=> !tickNow;
    endproperty
    a_half: assert property (p_half) else $error("half rate ticked twice");
    property p_succ;
        logic [2:0] s;
        @(posedge clk) disable iff (!nrst) (s_segEnd, s = cur.succ) |=> s_nextEnter(s);
    endproperty
    a_succ: assert property (p_succ) else $error("wrong successor");
    property p_len;
        @(posedge clk) disable iff (!nrst)
            state_q == ST_RUN && !enter_q && cur.adv == 2'h0 && endNow |-> tickCnt_q == cur.len;
    endproperty
    a_len: assert property (p_len) else $error("length end wrong");
    property p_count;
        @(posedge clk) disable iff (!nrst)
            endNow && stepSrc_q == 2'h0 |=> rCount_q == $past(rCount_q) + CNT_W'(1);
    endproperty
    a_count: assert property (p_count) else $error("ramp counter missed");
    property p_step;
        @(posedge clk) disable iff (!nrst)
            tickNow && runEn_q && $signed(limLo_q) <= $signed(sum)
            && $signed(sum) <= $signed(limHi_q)
            && sum[32] == sum[31] |=> acc_q == $past(sum[31:0]);
    endproperty
    a_step: assert property (p_step) else $error("step not added");
    property p_clamp;
        @(posedge clk) disable iff (!nrst)
            tickNow && runEn_q && $signed(limLo_q) <= $signed(limHi_q)
            |=> $signed(acc_q) <= $signed(limHi_q) && $signed(acc_q) >= $signed(limLo_q);
    endproperty
    a_clamp: assert property (p_clamp) else $error("limit exceeded");
endmodule

/* tb_rss_ramp_segment_sequencer.sv */
`timescale 1ns/1ps
`include "rss_consts.svh"
module tb_rss_ramp_segment_sequencer;
    import rss_pkg::*;
    logic clk;
    logic nrst;
    rss_apb_req_type apbReq;
    rss_apb_rsp_type apbRsp;
    logic [2:0] triggerPins;
    logic [31:0] rampValue;
    logic [31:0] rdData;
    logic rdErr;
    logic segmentFastSettle;
    logic markerOutputLow;
    logic markerOutputHigh;
    int errTotal = 0;
    int totalChecks = 0;

    rss_ramp_segment_sequencer dut (
        .clk(clk),
        .nrst(nrst),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .triggerPins(triggerPins),
        .rampValue(rampValue),
        .segmentFastSettle(segmentFastSettle),
        .markerOutputLow(markerOutputLow),
        .markerOutputHigh(markerOutputHigh)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finishTest();
        if (errTotal == 0 && totalChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high at a rising edge; a hang ends the run
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= wr;
        apbReq.paddr <= addr;
        apbReq.pwdata <= data;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        if (apbRsp.pready !== 1'b1) begin
            errTotal++;
            finishTest();
        end
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rdChk(input string what, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(what, rdData, exp);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic outChk(input string s, input logic [31:0] acc, input logic fs,
                          input logic [1:0] mk);
        check({s, " acc"}, rampValue, acc);
        check({s, " fast"}, {31'h0, segmentFastSettle}, {31'h0, fs});
        check({s, " marker"}, {30'h0, markerOutputHigh, markerOutputLow}, {30'h0, mk});
    endtask

    // triggers are edge events; the hold covers the input synchroniser
    task automatic pulse(input int i);
        @(posedge clk);
        triggerPins[i] <= 1'b1;
        repeat (4) @(posedge clk);
        triggerPins[i] <= 1'b0;
        waitc(10);
    endtask

    function automatic logic [31:0] ctl(int len, int fs, int hf, int mk, int clr, int adv,
                                        int succ);
        return 32'(len | (fs << 17) | (hf << 18) | (mk << 19) | (clr << 21) | (adv << 22)
                   | (succ << 24));
    endfunction

    task automatic testReset();
        waitc(1);
        outChk("idle", 32'h0, 1'b0, 2'h0);
        for (int n = 0; n < 8; n++) begin
            rdChk("step rst", `RSS_OFF_SEG_BASE + 12'(8 * n), 32'h0);
            rdChk("ctrl rst", `RSS_OFF_SEG_BASE + 12'(8 * n + 4), 32'h0);
        end
        rdChk("lim lo", `RSS_OFF_LIM_LO, `RSS_LIM_LO_RST);
        rdChk("lim hi", `RSS_OFF_LIM_HI, `RSS_LIM_HI_RST);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped err", {31'h0, rdErr}, 32'h1);
        check("unmapped data", rdData, 32'h0);
    endtask

    // distinct step words per index catch descriptors that alias each other; control words are all ones
    task automatic testRegs();
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, `RSS_OFF_SEG_BASE + 12'(8 * n), 32'h01000000 * 32'(n) + 32'h00ABCDEF);
            apb(1'b1, `RSS_OFF_SEG_BASE + 12'(8 * n + 4), 32'hFFFFFFFF);
        end
        for (int n = 0; n < 8; n++) begin
            rdChk("step rw", `RSS_OFF_SEG_BASE + 12'(8 * n),
                  32'h01000000 * 32'(n) + 32'h00ABCDEF);
            rdChk("ctrl rw", `RSS_OFF_SEG_BASE + 12'(8 * n + 4), 32'h07FFFFFF);
        end
        apb(1'b1, `RSS_OFF_ACCUM, 32'h12345678);
        rdChk("accum ro", `RSS_OFF_ACCUM, 32'h0);
    endtask

    task automatic testSequence();
        apb(1'b1, 12'h040, 32'h0000000A);
        apb(1'b1, 12'h044, ctl(3, 0, 0, 0, 1, 0, 1)); // clear on first segment
        apb(1'b1, 12'h048, 32'h3FFFFFFC);
        apb(1'b1, 12'h04C, ctl(2, 1, 1, 1, 0, 1, 2));
        apb(1'b1, 12'h050, 32'h00000007);
        apb(1'b1, 12'h054, ctl(0, 0, 0, 2, 0, 2, 3));
        apb(1'b1, 12'h058, 32'h0);
        apb(1'b1, 12'h05C, ctl(0, 0, 0, 3, 0, 3, 0));
        apb(1'b1, `RSS_OFF_CTRL, 32'h1);
        waitc(40);
        outChk("seg1", 32'd22, 1'b1, 2'h1);
        rdChk("status seg1", `RSS_OFF_STATUS, 32'h3);
        pulse(1);
        rdChk("wrong trigger", `RSS_OFF_STATUS, 32'h3);
        pulse(0);
        outChk("seg2", 32'd22, 1'b0, 2'h2);
        rdChk("status seg2", `RSS_OFF_STATUS, 32'h5);
        pulse(1);
        outChk("seg3", 32'd22, 1'b0, 2'h3);
        rdChk("count seg3", `RSS_OFF_RCOUNT, 32'h3);
        pulse(2);
        waitc(40);
        outChk("wrap", 32'd22, 1'b1, 2'h1);
        rdChk("count wrap", `RSS_OFF_RCOUNT, 32'h5);
        apb(1'b1, `RSS_OFF_CTRL, 32'h0);
        waitc(5);
        // stopping keeps the accumulator and the segment index, outputs drop
        outChk("stopped", 32'd22, 1'b0, 2'h0);
        rdChk("stopped", `RSS_OFF_STATUS, 32'h2);
    endtask

    task automatic testLimit();
        apb(1'b1, `RSS_OFF_LIM_HI, 32'd25);
        apb(1'b1, `RSS_OFF_CTRL, 32'h1);
        // run edge, entry, three ticks, end, entry, one idle half cycle, first slow tick
        waitc(9);
        check("half rate acc", rampValue, 32'd21);
        waitc(30);
        check("clamped acc", rampValue, 32'd17);
        // trigger zero as counter source: segment changes alone no longer count
        apb(1'b1, `RSS_OFF_CTRL, 32'h3);
        pulse(0);
        rdChk("count trig", `RSS_OFF_RCOUNT, 32'h7);
        pulse(1);
        rdChk("status src1", `RSS_OFF_STATUS, 32'h7);
        rdChk("count no seg", `RSS_OFF_RCOUNT, 32'h7);
        pulse(0);
        rdChk("count trig only", `RSS_OFF_RCOUNT, 32'h8);
        apb(1'b1, `RSS_OFF_CTRL, 32'h0);
    endtask

    initial begin
        apbReq = '0;
        triggerPins = 3'h0;
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        testReset();
        testRegs();
        testSequence();
        testLimit();
        finishTest();
    end

    // the whole run takes under a thousand cycles; this bound of 10000 cycles leaves ample slack
    initial begin
        #50000;
        errTotal++;
        finishTest();
    end
endmodule
